// *** hdl/sadc_pkg.sv ***
//----------------------------------------------------------------
// Functional notes
//----------------------------------------------------------------
// Functional notes
// - din high at start edge selects chip-select mode
// - din low at start edge selects daisy-chain
// - optional busy bit precedes the result bits
// - result is two's complement of half of pos minus neg
// - conversion timed by internal clock, bounded duration
// - serial clock used only for readout
// - inputs captured at conversion start
// - analog inputs disconnected while converting
// - reconnect, power down, result readable after conversion
// - four chip-select variants: 3/4-wire, busy or not
// - start edge tristates output, samples, starts conversion
// - no busy: release after 16th falling edge
// - busy: low busy bit, msb first, release after 17th
package sadc_pkg;

  //----------------------------------------------------------------
  // timing
  //----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;   // system clock period
  localparam int T_CONV_MIN_NS = 500;  // least conversion time
  localparam int T_CONV_MAX_NS = 710;  // longest conversion time
  localparam int CONV_MIN_CYC  = (T_CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC  = T_CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int CONV_SPREAD   = 15;   // largest random extra cycles
  localparam logic [6:0] CONV_MIN_CNT = 7'(CONV_MIN_CYC);

  //----------------------------------------------------------------
  // widths, counts and reset values
  //----------------------------------------------------------------
  localparam int RESULT_W = 16;        // result word width
  localparam int CNT_W    = 6;         // falling-edge counter width
  localparam int DBUF_AW  = 5;         // chained-bit buffer address width
  localparam logic [CNT_W-1:0] FALLS_NO_BUSY = 6'h10;  // frame length without busy bit
  localparam logic [CNT_W-1:0] WORD_BITS     = 6'h10;  // bits in one word
  localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [7:0] LFSR_SEED = 8'ha5;
  localparam logic [7:0] LFSR_TAPS = 8'hb8;

  //----------------------------------------------------------------
  // types
  //----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_ACQ  = 2'b01,                   // acquisition, powered down
    ST_CONV = 2'b10                    // converting
  } sadc_state_e;

  typedef struct packed {
    logic             active;          // frame driving the output
    logic             busy;            // frame opens with a busy bit
    logic [CNT_W-1:0] base;            // falling-edge count at frame start
  } sadc_frame_s;

  localparam sadc_frame_s FRAME_RST = '{active: 1'b0, busy: 1'b0, base: 6'h00};

endpackage

// *** hdl/sadc_sync.sv ***
`timescale 1ns/100ps
module sadc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1;       // first stage, read only by the second
  logic [WIDTH-1:0] next_s1;
  logic [WIDTH-1:0] next_q;

  // next values of both stages
  always_comb begin
    next_s1 = d;
    next_q  = s1;
  end

  // two stages against metastability
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      q  <= '0;
    end else begin
      s1 <= next_s1;
      q  <= next_q;
    end
  end

endmodule // sadc_sync

// *** hdl/sadc_top.sv ***
`timescale 1ns/100ps
module sadc_top (
  // system clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // host serial pins
  input  wire logic        CONVERSION_START_PIN,
  input  wire logic        DIN,
  input  wire logic        SCLK,
  output logic             DOUT,
  output logic             DOUT_OE,
  // analog side, digitised input levels
  input  wire logic [15:0] POSITIVE_ANALOG_INPUT,
  input  wire logic [15:0] NEGATIVE_ANALOG_INPUT,
  // status
  output logic             SAMPLE_SWITCH_CLOSED,
  output logic             POWERED_DOWN,
  output logic             CONVERTING,
  output logic             CS_MODE
);

  //----------------------------------------------------------------
  // reset release, one copy per domain
  //----------------------------------------------------------------
  logic rst_q1;               // first reset stage, system domain
  logic rst_n;                // released reset, system domain
  logic lrst_q1;              // first reset stage, link domain
  logic lrst_n;               // released reset, link domain

  // system reset: asserts at once, releases after two edges
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // link reset on the serial clock's falling edge
  always_ff @(negedge SCLK or negedge RESETN) begin
    if (!RESETN) begin
      lrst_q1 <= 1'b0;
      lrst_n  <= 1'b0;
    end else begin
      lrst_q1 <= 1'b1;
      lrst_n  <= lrst_q1;
    end
  end

  //----------------------------------------------------------------
  // link domain: counts falling edges, stores chained-in bits
  //----------------------------------------------------------------
  logic [sadc_pkg::CNT_W-1:0]          lcnt;       // falling edges seen
  logic [sadc_pkg::CNT_W-1:0]          lgray;      // gray copy for crossing
  logic [(1<<sadc_pkg::DBUF_AW)-1:0]   dbuf;       // din bits by edge index
  logic [sadc_pkg::CNT_W-1:0]          next_lcnt;
  logic [sadc_pkg::CNT_W-1:0]          next_lgray;
  logic [(1<<sadc_pkg::DBUF_AW)-1:0]   next_dbuf;

  // the serial clock only moves data out and in, never the conversion
  always_comb begin
    next_lcnt  = lcnt + 6'h01;
    next_lgray = next_lcnt ^ (next_lcnt >> 1);
    next_dbuf  = dbuf;
    next_dbuf[lcnt[sadc_pkg::DBUF_AW-1:0]] = DIN;
  end

  // a stopped serial clock just freezes this state, nothing waits on it
  always_ff @(negedge SCLK or negedge lrst_n) begin
    if (!lrst_n) begin
      lcnt  <= '0;
      lgray <= '0;
      dbuf  <= '0;
    end else begin
      lcnt  <= next_lcnt;
      lgray <= next_lgray;
      dbuf  <= next_dbuf;
    end
  end

  //----------------------------------------------------------------
  // crossings into the system domain
  //----------------------------------------------------------------
  logic                       conversion_start_pin_s;    // synchronised start pin
  logic                       din_s;       // synchronised data input
  logic [sadc_pkg::CNT_W-1:0] gray_s;      // synchronised edge count, gray
  logic [31:0]                ain_s;       // synchronised analog codes
  logic [sadc_pkg::CNT_W-1:0] fall_cnt;    // edge count, binary

  sadc_sync #(.WIDTH(2)) u_sync_pins (
    .clk   (CLK),
    .rst_n (rst_n),
    .d     ({CONVERSION_START_PIN, DIN}),
    .q     ({conversion_start_pin_s, din_s})
  );

  sadc_sync #(.WIDTH(sadc_pkg::CNT_W)) u_sync_cnt (
    .clk   (CLK),
    .rst_n (rst_n),
    .d     (lgray),
    .q     (gray_s)
  );

  sadc_sync #(.WIDTH(32)) u_sync_ain (
    .clk   (CLK),
    .rst_n (rst_n),
    .d     ({POSITIVE_ANALOG_INPUT, NEGATIVE_ANALOG_INPUT}),
    .q     (ain_s)
  );

  // gray back to binary; only one bit moves per edge, so no torn value
  always_comb begin
    fall_cnt[sadc_pkg::CNT_W-1] = gray_s[sadc_pkg::CNT_W-1];
    for (int i = sadc_pkg::CNT_W - 2; i >= 0; i--) begin
      fall_cnt[i] = fall_cnt[i+1] ^ gray_s[i];
    end
  end

  //----------------------------------------------------------------
  // conversion sequencer and readout framing
  //----------------------------------------------------------------
  sadc_pkg::sadc_state_e              state;       // acquire or convert
  logic [6:0]                         cnt;         // conversion cycles left
  logic [7:0]                         lfsr;        // spreads conversion time
  logic                               mode_cs;     // 1 chip-select, 0 daisy
  logic                               conversion_start_pin_q;    // start pin, last cycle
  logic                               sel_q;       // select, last cycle
  logic [15:0]                        pos_held;    // held positive sample
  logic [15:0]                        neg_held;    // held negative sample
  logic [sadc_pkg::RESULT_W-1:0]      result;      // finished word
  sadc_pkg::sadc_frame_s              frame;       // readout frame
  logic                               sw_closed;   // sampling switch
  logic                               pwr_down;    // acquisition power-down
  logic                               dout;        // output data bit
  logic                               dout_oe;     // output enable

  sadc_pkg::sadc_state_e              next_state;
  logic [6:0]                         next_cnt;
  logic [7:0]                         next_lfsr;
  logic                               next_mode_cs;
  logic [15:0]                        next_pos_held;
  logic [15:0]                        next_neg_held;
  logic [sadc_pkg::RESULT_W-1:0]      next_result;
  sadc_pkg::sadc_frame_s              next_frame;
  logic                               next_sw_closed;
  logic                               next_pwr_down;
  logic                               next_dout;
  logic                               next_dout_oe;

  logic                               start;       // start pin rising
  logic                               sel;         // host selects output
  logic [16:0]                        diff;        // pos minus neg
  logic [sadc_pkg::CNT_W-1:0]         pos;         // bit position in frame
  logic [sadc_pkg::CNT_W-1:0]         limit;       // frame length
  logic [sadc_pkg::CNT_W-1:0]         k;           // word bit index
  logic [sadc_pkg::CNT_W-1:0]         chain_idx;   // chained bit edge index

  // sequencing, selection, framing and the output bit
  always_comb begin
    start = conversion_start_pin_s & ~conversion_start_pin_q;
    // 3-wire: start pin low selects; 4-wire: din low selects
    sel   = mode_cs ? ~(conversion_start_pin_s & din_s) : ~conversion_start_pin_s;
    diff  = {1'b0, pos_held} - {1'b0, neg_held};
    next_state     = state;
    next_cnt       = cnt;
    next_lfsr      = {lfsr[6:0], ^(lfsr & sadc_pkg::LFSR_TAPS)};
    next_mode_cs   = mode_cs;
    next_pos_held  = pos_held;
    next_neg_held  = neg_held;
    next_result    = result;
    next_frame     = frame;
    next_sw_closed = sw_closed;
    next_pwr_down  = pwr_down;
    if (start) begin
      // latch mode once per start edge, held until the next
      next_mode_cs   = din_s;
      next_pos_held  = ain_s[31:16];
      next_neg_held  = ain_s[15:0];
      // internal timing with a bounded random spread
      next_cnt       = sadc_pkg::CONV_MIN_CNT + {3'h0, lfsr[3:0]};
      next_state     = sadc_pkg::ST_CONV;
      next_frame     = sadc_pkg::FRAME_RST;
      next_sw_closed = 1'b0;
      next_pwr_down  = 1'b0;
    end else begin
      unique case (state)
        sadc_pkg::ST_CONV: begin
          if (cnt == 7'h01) begin
            // halve the 17-bit difference into a 16-bit signed word
            next_result    = diff[16:1];
            next_state     = sadc_pkg::ST_ACQ;
            next_sw_closed = 1'b1;
            next_pwr_down  = 1'b1;
            if (sel) begin
              // selected at the end: open with a busy bit
              next_frame.active = 1'b1;
              next_frame.busy   = 1'b1;
              next_frame.base   = fall_cnt;
            end
          end else begin
            next_cnt = cnt - 7'h01;
          end
        end
        sadc_pkg::ST_ACQ: begin
          // a select edge opens readout in acquisition, after the word is ready
          if (!frame.active && sel && !sel_q) begin
            next_frame.active = 1'b1;
            next_frame.busy   = 1'b0;
            next_frame.base   = fall_cnt;
          end
        end
      endcase
    end
    // frame end: deselect, or the last edge in chip-select mode
    pos   = fall_cnt - next_frame.base;
    limit = sadc_pkg::FALLS_NO_BUSY + {5'h00, next_frame.busy};
    if (next_frame.active && (!sel || (next_mode_cs && (pos >= limit)))) begin
      next_frame.active = 1'b0;
    end
    // bit on the wire: busy, word msb first, then chained bits
    k         = pos - {5'h00, next_frame.busy};
    chain_idx = fall_cnt - sadc_pkg::WORD_BITS - {5'h00, next_frame.busy};
    next_dout_oe = next_frame.active;
    if (next_frame.busy && (pos == 6'h00)) begin
      next_dout = 1'b0;
    end else if (k < sadc_pkg::WORD_BITS) begin
      next_dout = next_result[~k[3:0]];
    end else begin
      // daisy tail: the upstream bit seen one word earlier, or a word and one bit in busy frames
      next_dout = dbuf[chain_idx[sadc_pkg::DBUF_AW-1:0]];
    end
  end

  // register the sequencer
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state     <= sadc_pkg::ST_ACQ;
      cnt       <= 7'h00;
      lfsr      <= sadc_pkg::LFSR_SEED;
      mode_cs   <= 1'b1;
      conversion_start_pin_q  <= 1'b0;
      sel_q     <= 1'b1;  // select reads high in reset, so no false edge after it
      pos_held  <= 16'h0000;
      neg_held  <= 16'h0000;
      result    <= sadc_pkg::RESULT_RST;
      frame     <= sadc_pkg::FRAME_RST;
      sw_closed <= 1'b1;
      pwr_down  <= 1'b1;
      dout      <= 1'b0;
      dout_oe   <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      lfsr      <= next_lfsr;
      mode_cs   <= next_mode_cs;
      conversion_start_pin_q  <= conversion_start_pin_s;
      sel_q     <= sel;
      pos_held  <= next_pos_held;
      neg_held  <= next_neg_held;
      result    <= next_result;
      frame     <= next_frame;
      sw_closed <= next_sw_closed;
      pwr_down  <= next_pwr_down;
      dout      <= next_dout;
      dout_oe   <= next_dout_oe;
    end
  end

  //----------------------------------------------------------------
  // outputs, all straight from flops
  //----------------------------------------------------------------
  always_comb begin
    DOUT                 = dout;
    DOUT_OE              = dout_oe;
    SAMPLE_SWITCH_CLOSED = sw_closed;
    POWERED_DOWN         = pwr_down;
    CONVERTING           = state[1];  // one-hot bit of the convert state, straight from its flop
    CS_MODE              = mode_cs;
  end

endmodule // sadc_top

// *** verification/sadc_host.sv ***
`timescale 1ns/100ps
module sadc_host (
  // serial lines
  output logic      sclk,
  input  wire logic dout_line,
  output logic      sdo
);
  initial sclk = 1'b1;  // idles high, still outside frames
  initial sdo = 1'b0;
  // one frame of n falls at a 30 ns period; also called once before any result, to release the link reset
  task automatic read(input int n, input logic [15:0] ch, output logic [32:0] w);
    w = '0;
    #2.3;
    for (int i = 0; i < n; i++) begin
      sdo = (i < 16) ? ch[15 - i] : ~sdo;  // chained bit, set up before the fall
      #15;
      w = {w[31:0], dout_line};  // taken at the fall: the last fall's bit landed about 28 ns after it
      sclk = 1'b0;
      #15;
      sclk = 1'b1;
    end
    sdo = ~sdo;  // released line shows no stale value
  endtask
endmodule // sadc_host

// *** verification/sadc_top_assertions.sv ***
`timescale 1ns/100ps
module sadc_top_assertions (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RESETN,
  // host pins
  input wire logic        CONVERSION_START_PIN,
  input wire logic        DIN,
  input wire logic        SCLK,
  input wire logic        DOUT,
  input wire logic        DOUT_OE,
  // analog codes
  input wire logic [15:0] POSITIVE_ANALOG_INPUT,
  input wire logic [15:0] NEGATIVE_ANALOG_INPUT,
  // status
  input wire logic        SAMPLE_SWITCH_CLOSED,
  input wire logic        POWERED_DOWN,
  input wire logic        CONVERTING,
  input wire logic        CS_MODE
);
  //------------
  // properties
  //------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  logic [7:0] conv_len;       // cycles spent converting so far
  logic [7:0] next_conv_len;  // next value of the count
  // count restarts at zero in acquisition
  always_comb next_conv_len = CONVERTING ? conv_len + 8'h01 : 8'h00;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) conv_len <= 8'h00;
    else conv_len <= next_conv_len;
  end
  // mode pin must stay put a few cycles, as the synchroniser lags
  sequence cs_start_s; $rose(CONVERSION_START_PIN) && DIN ##1 DIN [*4]; endsequence
  sequence dc_start_s; $rose(CONVERSION_START_PIN) && !DIN ##1 !DIN [*4]; endsequence
  sequence conv_end_s; $fell(CONVERTING) ##[0:1] $rose(DOUT_OE); endsequence
  conv_start_a: assert property ($rose(CONVERSION_START_PIN) |-> ##[2:5] CONVERTING)
    else $error("no conversion after start edge");
  conv_hiz_a: assert property (CONVERTING |-> !DOUT_OE)
    else $error("output driven during conversion");
  conv_open_a: assert property (CONVERTING |-> !SAMPLE_SWITCH_CLOSED)
    else $error("inputs connected during conversion");
  acq_enter_a: assert property ($fell(CONVERTING) |-> POWERED_DOWN && SAMPLE_SWITCH_CLOSED)
    else $error("acquisition not entered");
  conv_time_a: assert property ($fell(CONVERTING) |->
                                conv_len >= sadc_pkg::CONV_MIN_CYC && conv_len <= sadc_pkg::CONV_MAX_CYC)
    else $error("conversion length out of bounds");
  cs_mode_a: assert property (cs_start_s |-> ##[0:2] CS_MODE)
    else $error("chip-select mode not selected");
  dc_mode_a: assert property (dc_start_s |-> ##[0:2] !CS_MODE)
    else $error("daisy mode not selected");
  mode_hold_a: assert property ($changed(CS_MODE) |-> $rose(CONVERTING))
    else $error("mode changed outside a start");
  busy_low_a: assert property (conv_end_s |-> !DOUT)
    else $error("busy bit not low");
endmodule // sadc_top_assertions

bind sadc_top sadc_top_assertions u_chk (.CLK(CLK), .RESETN(RESETN), .CONVERSION_START_PIN(CONVERSION_START_PIN),
  .DIN(DIN), .SCLK(SCLK), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .POSITIVE_ANALOG_INPUT(POSITIVE_ANALOG_INPUT),
  .NEGATIVE_ANALOG_INPUT(NEGATIVE_ANALOG_INPUT), .SAMPLE_SWITCH_CLOSED(SAMPLE_SWITCH_CLOSED),
  .POWERED_DOWN(POWERED_DOWN), .CONVERTING(CONVERTING), .CS_MODE(CS_MODE));

// *** verification/sadc_top_tb_top.sv ***
`timescale 1ns/100ps
module sadc_top_tb_top;
  //-------
  // bench
  //-------
  logic        clk, rst_n, pin, din_lvl, chn, dout, dout_oe, sw, pd, conv, csm, sclk, sdo;
  logic [15:0] pos, neg, pv, nv;
  logic [32:0] w0;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc_cnt = 0;
  wire         din  = chn ? sdo : din_lvl;    // chained data only inside daisy frames
  wire         line = dout_oe ? dout : 1'b1;  // pull-up holds a released line high

  sadc_top dut (.CLK(clk), .RESETN(rst_n), .CONVERSION_START_PIN(pin), .DIN(din), .SCLK(sclk),
    .DOUT(dout), .DOUT_OE(dout_oe), .POSITIVE_ANALOG_INPUT(pos), .NEGATIVE_ANALOG_INPUT(neg),
    .SAMPLE_SWITCH_CLOSED(sw), .POWERED_DOWN(pd), .CONVERTING(conv), .CS_MODE(csm));
  sadc_host host (.sclk(sclk), .dout_line(line), .sdo(sdo));

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // result word: halved difference, two's complement
  function automatic logic [15:0] exp_word(input logic [15:0] p, input logic [15:0] n);
    logic [16:0] d;
    d = {1'b0, p} - {1'b0, n};
    return d[16:1];
  endfunction
  // one conversion and readout; fw picks the data pin as select
  task automatic run_case(input logic cs, input logic bz, input logic fw, input logic [15:0] p,
                          input logic [15:0] n);
    logic [15:0] ch;
    logic [32:0] w;
    int          k;
    ch = 16'($urandom);
    din_lvl = 1'b1;
    pin = 1'b0;
    cyc(5);
    din_lvl = cs;
    pos = p;
    neg = n;
    cyc(3);
    pin = 1'b1;
    k = 0;
    while (conv !== 1'b1 && k < 10) begin
      cyc(1);
      k++;
    end
    chk(sw === 1'b0 && pd === 1'b0 && dout_oe === 1'b0, "start");
    chk(csm === cs, "mode");
    cyc(10);
    pos = ~p;  // later levels must not reach this result
    neg = ~n;
    if (bz && fw) din_lvl = 1'b0;
    if (bz && !fw) pin = 1'b0;
    k = 10;
    while (conv === 1'b1 && k < 100) begin
      cyc(1);
      k++;
    end
    chk(k >= sadc_pkg::CONV_MIN_CYC - 1 && k <= sadc_pkg::CONV_MAX_CYC + 1, "length");
    cyc(2);
    chk(pd === 1'b1 && sw === 1'b1, "acquisition");
    chk(dout_oe === bz, "busy");
    if (!bz && fw) din_lvl = 1'b0;
    if (!bz && !fw) pin = 1'b0;
    cyc(4);
    chk(dout_oe === 1'b1, "open");
    chn = !cs;
    // daisy: word, then the chained bits one word later; a busy bit leads in either mode
    host.read(cs ? 16 + int'(bz) : 32 + int'(bz), ch, w);
    chn = 1'b0;
    cyc(6);
    if (cs)
      chk(w[16:0] === {1'b0, exp_word(p, n)} && dout_oe === 1'b0, "frame");
    else
      chk(w === {1'b0, exp_word(p, n), ch}, "chain");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far beyond twelve cases
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    rst_n = 1'b0;
    pin = 1'b0;
    din_lvl = 1'b1;
    chn = 1'b0;
    pos = 16'h0000;
    neg = 16'h0000;
    void'($urandom(32'hfbae));
    cyc(3);
    rst_n = 1'b1;
    cyc(4);
    host.read(2, 16'h0000, w0);  // link side leaves reset on two falls
    // cases: 3-wire, 3-wire busy, 4-wire, 4-wire busy, daisy, daisy busy
    for (int i = 0; i < 12; i++) begin
      pv = 16'($urandom);
      nv = 16'($urandom);
      if (i == 0) pv = 16'hffff;
      if (i == 0) nv = 16'h0000;
      if (i == 1) pv = 16'h0000;
      if (i == 1) nv = 16'hffff;
      run_case(i % 6 < 4, i % 2 == 1, i % 6 == 2 || i % 6 == 3, pv, nv);
    end
    summarize();
  end
endmodule // sadc_top_tb_top
